// *** rtl/cmxm_pkg.sv ***
/*
 Package for the message-interface transfer mask block: mask bit positions,
 message-control field positions, widths, reset values and transfer states.
 Assumes a single clock domain and one message object per transfer.
*/
package cmxm_pkg;
    localparam int CTRL_W            = 16;
    localparam int OBJ_NUM_W         = 6;
    localparam int MASK_W            = 8;
    // Command mask bit positions
    localparam int MASK_CONTROL_BIT  = 4;
    localparam int MASK_CLR_IRQ_BIT  = 3;
    localparam int MASK_NEW_DATA_FLAG_BIT   = 2;
    // Message-control field positions
    localparam int MCTL_NEW_DATA_FLAG_BIT   = 15;
    localparam int MCTL_IRQ_PEND_BIT = 13;
    localparam int MCTL_TXRQ_BIT     = 8;
    localparam logic [15:0] MCTL_RESET = 16'h0000;
    localparam logic [7:0]  MASK_RESET = 8'h00;
    localparam logic [5:0]  OBJ_RESET  = 6'h00;

    typedef enum logic [1:0] {
        CMXM_IDLE  = 2'b00,
        CMXM_READ  = 2'b01,
        CMXM_WRITE = 2'b10,
        CMXM_DONE  = 2'b11
    } cmxm_state_t;
endpackage

// *** rtl/cmxm_transfer_mask.sv ***
/*
 Transfer-mask logic between the message interface registers and message RAM.
 Handles control-bit transfer, interrupt-pending clear and new-data/transmit
 request per transfer direction. Assumes a synchronous RAM with one-cycle read
 latency and same-clock software-side control ports.
*/
`timescale 1ns/1ps
module cmxm_transfer_mask (
    input  wire logic                            mclk,
    input  wire logic                            rst_n,
    input  wire logic                            clk_en,
    input  wire logic                            start,
    input  wire logic                            write_not_read,
    input  wire logic [cmxm_pkg::MASK_W-1:0]     transfer_mask,
    input  wire logic [cmxm_pkg::OBJ_NUM_W-1:0]  object_num,
    input  wire logic [cmxm_pkg::CTRL_W-1:0]     if_message_control_reg,
    input  wire logic [cmxm_pkg::CTRL_W-1:0]     ram_rdata,
    output logic                                 busy,
    output logic      [cmxm_pkg::CTRL_W-1:0]     if_ctrl_result,
    output logic                                 if_ctrl_result_valid,
    output logic                                 ram_rd,
    output logic                                 ram_wr,
    output logic      [cmxm_pkg::OBJ_NUM_W-1:0]  ram_addr,
    output logic      [cmxm_pkg::CTRL_W-1:0]     ram_wdata
);
    import cmxm_pkg::*;

    cmxm_state_t          state_ff,  nxt_state;
    logic [MASK_W-1:0]    mask_ff,   nxt_mask;
    logic                 wr_ff,     nxt_wr;
    logic [OBJ_NUM_W-1:0] obj_ff,    nxt_obj;
    logic [CTRL_W-1:0]    req_ff,    nxt_req;
    logic [CTRL_W-1:0]    result_ff, nxt_result;
    logic                 rvalid_ff, nxt_rvalid;
    logic                 rd_ff,     nxt_rd;
    logic                 wen_ff,    nxt_wen;
    logic [CTRL_W-1:0]    wdata_ff,  nxt_wdata;
    logic [CTRL_W-1:0]    merged;
    logic                 take;
    logic                 act;

    // Modify the fetched word so untouched fields are preserved in RAM
    always_comb begin
        merged = ram_rdata;
        if (wr_ff) begin
            if (mask_ff[MASK_CONTROL_BIT]) begin
                merged = req_ff;
            end
            if (mask_ff[MASK_CLR_IRQ_BIT]) begin
                merged[MCTL_IRQ_PEND_BIT] = 1'b0;
            end else begin
                merged[MCTL_IRQ_PEND_BIT] = ram_rdata[MCTL_IRQ_PEND_BIT];
            end
            if (mask_ff[MASK_NEW_DATA_FLAG_BIT]) begin
                merged[MCTL_TXRQ_BIT] = 1'b1;
            end
        end else begin
            if (mask_ff[MASK_CLR_IRQ_BIT]) begin
                merged[MCTL_IRQ_PEND_BIT] = 1'b0;
            end
            if (mask_ff[MASK_NEW_DATA_FLAG_BIT]) begin
                merged[MCTL_NEW_DATA_FLAG_BIT] = 1'b0;
            end
        end
    end

    // Start is refused while busy
    assign take = (state_ff == CMXM_IDLE) && start;
    // RAM word is only valid once the fetch strobe has gone
    assign act  = ((state_ff == CMXM_READ) || (state_ff == CMXM_WRITE)) && !rd_ff;

    // Sequence; the fetch cycle waits out the RAM read latency
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            CMXM_IDLE: begin
                if (start) begin
                    nxt_state = write_not_read ? CMXM_WRITE : CMXM_READ;
                end
            end
            CMXM_READ: begin
                if (!rd_ff) begin
                    nxt_state = CMXM_DONE;
                end
            end
            CMXM_WRITE: begin
                if (!rd_ff) begin
                    nxt_state = CMXM_DONE;
                end
            end
            CMXM_DONE: begin
                nxt_state = CMXM_IDLE;
            end
            default: begin
                nxt_state = CMXM_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= CMXM_IDLE;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    // Settings are sampled only at start, so late changes are harmless
    always_comb begin
        nxt_mask = mask_ff;
        nxt_wr   = wr_ff;
        nxt_obj  = obj_ff;
        nxt_req  = req_ff;
        if (take) begin
            nxt_mask = transfer_mask;
            nxt_wr   = write_not_read;
            nxt_obj  = object_num;
            nxt_req  = if_message_control_reg;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mask_ff <= MASK_RESET;
            wr_ff   <= 1'b0;
            obj_ff  <= OBJ_RESET;
            req_ff  <= MCTL_RESET;
        end else if (clk_en) begin
            mask_ff <= nxt_mask;
            wr_ff   <= nxt_wr;
            obj_ff  <= nxt_obj;
            req_ff  <= nxt_req;
        end
    end

    // Copy taken before clearing, so old status is reported
    always_comb begin
        nxt_result = result_ff;
        nxt_rvalid = 1'b0;
        if (act && !wr_ff) begin
            if (mask_ff[MASK_CONTROL_BIT]) begin
                nxt_result = ram_rdata;
            end else begin
                nxt_result[MCTL_IRQ_PEND_BIT] = ram_rdata[MCTL_IRQ_PEND_BIT];
                nxt_result[MCTL_NEW_DATA_FLAG_BIT]   = ram_rdata[MCTL_NEW_DATA_FLAG_BIT];
            end
            nxt_rvalid = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            result_ff <= MCTL_RESET;
            rvalid_ff <= 1'b0;
        end else if (clk_en) begin
            result_ff <= nxt_result;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // Read-back skips the RAM write unless something must be cleared
    always_comb begin
        nxt_rd    = take;
        nxt_wen   = 1'b0;
        nxt_wdata = wdata_ff;
        if (act) begin
            if (wr_ff) begin
                nxt_wen = 1'b1;
            end else begin
                nxt_wen = mask_ff[MASK_CLR_IRQ_BIT] | mask_ff[MASK_NEW_DATA_FLAG_BIT];
            end
            nxt_wdata = merged;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ff    <= 1'b0;
            wen_ff   <= 1'b0;
            wdata_ff <= MCTL_RESET;
        end else if (clk_en) begin
            rd_ff    <= nxt_rd;
            wen_ff   <= nxt_wen;
            wdata_ff <= nxt_wdata;
        end
    end

    assign busy                 = (state_ff != CMXM_IDLE);
    assign if_ctrl_result       = result_ff;
    assign if_ctrl_result_valid = rvalid_ff;
    assign ram_rd               = rd_ff;
    assign ram_wr               = wen_ff;
    assign ram_addr             = obj_ff;
    assign ram_wdata            = wdata_ff;
endmodule

// *** verification/cmxm_ram_model.sv ***
/* Message RAM model: 64 words, read data one cycle after the read strobe.
   Assumes strobes from the transfer block on mclk. */
`timescale 1ns/1ps
module cmxm_ram_model (
    input  wire logic        mclk,
    input  wire logic        ram_rd,
    input  wire logic        ram_wr,
    input  wire logic [5:0]  ram_addr,
    input  wire logic [15:0] ram_wdata,
    output logic      [15:0] ram_rdata
);
    logic [15:0] mem [64];
    initial begin
        foreach (mem[i]) mem[i] = 16'hffff;
        ram_rdata = 16'h0000;
    end
    // Read word held until next read, so a late sample still sees the old word
    always @(posedge mclk) begin
        if (ram_rd) ram_rdata <= mem[ram_addr];
        if (ram_wr) mem[ram_addr] <= ram_wdata;
    end
endmodule

// *** verification/cmxm_transfer_mask_checker.sv ***
/* Port assertions for the transfer mask block.
   Assumes clk_en high and inputs held through each transfer. */
`timescale 1ns/1ps
module cmxm_transfer_mask_checker (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        start,
    input wire logic        write_not_read,
    input wire logic [7:0]  transfer_mask,
    input wire logic [15:0] if_message_control_reg,
    input wire logic [15:0] ram_rdata,
    input wire logic        busy,
    input wire logic [15:0] if_ctrl_result,
    input wire logic        if_ctrl_result_valid,
    input wire logic        ram_rd,
    input wire logic        ram_wr,
    input wire logic [15:0] ram_wdata
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_busy_run;
        busy[*3] ##1 !busy;
    endsequence
    a_start_launch: assert property (start && !busy |=> ram_rd && busy) else $error("no launch");
    a_busy_span: assert property ($rose(busy) |-> s_busy_run) else $error("busy span wrong");
    a_wr_ctrl_move: assert property (ram_wr && write_not_read |-> ram_wdata[7:0] ==
        (transfer_mask[4] ? if_message_control_reg[7:0] : ram_rdata[7:0])) else $error("ctrl");
    a_wr_pend_clr: assert property (ram_wr && write_not_read |->
        ram_wdata[13] == (ram_rdata[13] && !transfer_mask[3])) else $error("pend on write");
    a_wr_txreq: assert property (ram_wr && write_not_read && transfer_mask[2]
        |-> ram_wdata[8]) else $error("txreq not set");
    a_rd_copy_old: assert property (if_ctrl_result_valid |->
        {if_ctrl_result[15], if_ctrl_result[13]} == {ram_rdata[15], ram_rdata[13]})
        else $error("copy");
    a_rd_clear_buf: assert property (ram_wr && !write_not_read |->
        ram_wdata[15] == (ram_rdata[15] && !transfer_mask[2]) &&
        ram_wdata[13] == (ram_rdata[13] && !transfer_mask[3])) else $error("clear on read");
    a_rd_keep_buf: assert property (ram_rd && !write_not_read && transfer_mask[3:2] == 2'h0
        |=> !ram_wr[*3]) else $error("read wrote back");
endmodule

// *** verification/cmxm_transfer_mask_tb.sv ***
/* Row-driven bench for the transfer mask block with a RAM model.
   Assumes one clock; clk_en kept high, inputs held until busy drops. */
`timescale 1ns/1ps
bind cmxm_transfer_mask cmxm_transfer_mask_checker cmxm_transfer_mask_checker_i (.mclk, .rst_n,
    .start, .write_not_read, .transfer_mask, .if_message_control_reg, .ram_rdata, .busy,
    .if_ctrl_result, .if_ctrl_result_valid, .ram_rd, .ram_wr, .ram_wdata);
module cmxm_transfer_mask_tb;
    import cmxm_pkg::*;
    typedef struct packed {
        logic wnr; logic [7:0] mask; logic [5:0] obj; logic [15:0] ctl; logic [15:0] res;
    } cmxm_row_t;
    logic mclk, rst_n, clk_en, start, write_not_read, busy, if_ctrl_result_valid, ram_rd, ram_wr;
    logic [7:0]  transfer_mask;
    logic [5:0]  object_num, ram_addr;
    logic [15:0] if_message_control_reg, ram_rdata, if_ctrl_result, ram_wdata;
    int          n_errors = 0;
    int          checks_done = 0;
    cmxm_row_t   rows [12] = '{
        '{1'h0, 8'h00, 6'h05, 16'h0000, 16'ha000}, '{1'h0, 8'h10, 6'h05, 16'h0000, 16'hffff},
        '{1'h0, 8'h1c, 6'h05, 16'h0000, 16'hffff}, '{1'h0, 8'h10, 6'h05, 16'h0000, 16'h5fff},
        '{1'h1, 8'h10, 6'h05, 16'ha0f0, 16'h0000}, '{1'h1, 8'h00, 6'h05, 16'h0000, 16'h0000},
        '{1'h0, 8'h10, 6'h05, 16'h0000, 16'h80f0}, '{1'h1, 8'h04, 6'h05, 16'h0000, 16'h0000},
        '{1'h0, 8'h10, 6'h05, 16'h0000, 16'h81f0}, '{1'h1, 8'h08, 6'h06, 16'h0000, 16'h0000},
        '{1'h0, 8'h10, 6'h06, 16'h0000, 16'hdfff}, '{1'h1, 8'h14, 6'h07, 16'h0000, 16'h0000}};
    cmxm_transfer_mask cmxm_transfer_mask_i (.mclk, .rst_n, .clk_en, .start, .write_not_read,
        .transfer_mask, .object_num, .if_message_control_reg, .ram_rdata, .busy,
        .if_ctrl_result, .if_ctrl_result_valid, .ram_rd, .ram_wr, .ram_addr, .ram_wdata);
    cmxm_ram_model cmxm_ram_model_i (.mclk, .ram_rd, .ram_wr, .ram_addr, .ram_wdata, .ram_rdata);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Setup and start on the same negedge, start held for hold cycles, then wait for busy to drop
    task automatic xfer(input cmxm_row_t r, input int hold);
        int n;
        @(negedge mclk);
        {write_not_read, transfer_mask, object_num, if_message_control_reg} = r[46:16];
        start = 1'h1;
        repeat (hold) @(negedge mclk);
        start = 1'h0;
        for (n = 0; n < 20 && busy !== 1'h0; n++) @(negedge mclk);
        if (n == 20) begin
            n_errors++;
            wrap_up();
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        {rst_n, start, write_not_read, transfer_mask, object_num, if_message_control_reg} = '0;
        clk_en = 1'h1;
        repeat (8) @(negedge mclk);
        chk({if_ctrl_result[15:1], busy}, 16'h0000);
        rst_n = 1'h1;
        foreach (rows[i]) begin
            xfer(rows[i], 1);
            if (!rows[i].wnr) chk(if_ctrl_result, rows[i].res);
        end
        xfer('{1'h0, 8'h10, 6'h07, 16'h0000, 16'h0000}, 1);
        chk(if_ctrl_result, 16'h2100);
        // Start held into busy must be ignored, else the cleared word would show
        xfer('{1'h0, 8'h1c, 6'h08, 16'h0000, 16'h0000}, 2);
        chk(if_ctrl_result, 16'hffff);
        // Reset in mid-transfer clears outputs but leaves RAM alone
        @(negedge mclk);
        {write_not_read, transfer_mask, object_num} = {1'h0, 8'h10, 6'h05};
        start = 1'h1;
        @(negedge mclk);
        start = 1'h0;
        rst_n = 1'h0;
        @(negedge mclk);
        chk(if_ctrl_result, 16'h0000);
        chk({9'h000, ram_addr, busy}, 16'h0000);
        chk({13'h0000, ram_rd, ram_wr, if_ctrl_result_valid}, 16'h0000);
        rst_n = 1'h1;
        xfer('{1'h0, 8'h10, 6'h05, 16'h0000, 16'h0000}, 1);
        chk(if_ctrl_result, 16'h81f0);
        chk({10'h000, ram_addr}, 16'h0005);
        wrap_up();
    end
endmodule
